// [hdl/dsp_regfile_pkg.sv]
// Constants and types shared by the DSP register file.
package dsp_regfile_pkg;
   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int ACC_W = 40;
   localparam int BODY_W = 32;
   localparam int GUARD_W = 8;
   localparam int STAT_W = 8;
   localparam int DATA_CNT = 6;
   localparam int ACC_CNT = 2;
   // -----------------------------------------------------------------
   // Status field positions and reset value
   // -----------------------------------------------------------------
   localparam int GT_BIT = 7;
   localparam int EQ_BIT = 6;
   localparam int LT_BIT = 5;
   localparam int WRAP_BIT = 4;
   localparam int CS_HI = 3;
   localparam int CS_LO = 1;
   localparam int DC_BIT = 0;
   localparam logic [31:0] STAT_RESET = 32'h0000_0000;
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;
   // -----------------------------------------------------------------
   // Register selectors, condition modes and operation kinds
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      SEL_ACCUM_FIRST = 4'h0,
      SEL_ACCUM_SECOND = 4'h1,
      SEL_ACCUM_FIRST_GUARD = 4'h2,
      SEL_ACCUM_SECOND_GUARD = 4'h3,
      SEL_MULT_REG_FIRST = 4'h4,
      SEL_MULT_REG_SECOND = 4'h5,
      SEL_XBUS_REG_FIRST = 4'h6,
      SEL_XBUS_REG_SECOND = 4'h7,
      SEL_YBUS_REG_FIRST = 4'h8,
      SEL_YBUS_REG_SECOND = 4'h9,
      SEL_COND_STATUS = 4'hA
   } reg_sel_t;
   localparam logic [3:0] DATA_BASE = 4'h4;
   typedef enum logic [2:0] {
      CS_CARRY = 3'h0,
      CS_NEGATIVE = 3'h1,
      CS_ZERO = 3'h2,
      CS_OVERFLOW = 3'h3,
      CS_SIGNED_GREATER = 3'h4,
      CS_SIGNED_ABOVE = 3'h5
   } cond_sel_t;
   typedef enum logic [1:0] {
      OP_ARITH = 2'h0,
      OP_PACKED_MUL = 2'h1,
      OP_TRANSFER = 2'h3
   } op_kind_t;
endpackage

// [hdl/dsp_regfile.sv]
// DSP unit register file with accumulators, data registers and status.
`timescale 1ns/1ps
`default_nettype none
module dsp_regfile
   import dsp_regfile_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Core system-register port
   input wire logic sysWrEn,
   input wire logic [3:0] sysWrSel,
   input wire logic [31:0] sysWrData,
   input wire logic [3:0] sysRdSel,
   output logic [31:0] sysRdData,
   // DSP datapath write-back
   input wire logic dspWrEn,
   input wire logic [3:0] dspWrSel,
   input wire logic [39:0] dspWrData,
   input wire logic [1:0] dspKind,
   input wire logic dspCondOp,
   input wire logic dspCarry,
   // DSP operand read ports
   input wire logic [3:0] srcASel,
   input wire logic [3:0] srcBSel,
   output logic [39:0] srcAData,
   output logic [39:0] srcBData,
   // Status view
   output logic [7:0] statusFlags,
   output logic dspCondFlag,
   output logic dspWrDone
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ACC_CNT-1:0][ACC_W-1:0] acc;
      logic [DATA_CNT-1:0][BODY_W-1:0] dat;
      logic [STAT_W-1:0] stat;
      logic [31:0] rd;
      logic [39:0] opA;
      logic [39:0] opB;
      logic done;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic isData(input logic [3:0] sel);
      isData = (sel >= DATA_BASE) && (sel <= SEL_YBUS_REG_SECOND);
   endfunction

   function automatic logic [2:0] dataIdx(input logic [3:0] sel);
      logic [3:0] d;
      d = sel - DATA_BASE;
      dataIdx = d[2:0];
   endfunction

   function automatic logic [39:0] operand(input state_t s, input logic [3:0] sel);
      logic [31:0] w;
      operand = '0;
      w = '0;
      if (sel == SEL_ACCUM_FIRST || sel == SEL_ACCUM_SECOND) begin
         operand = s.acc[sel[0]];
      end else if (sel == SEL_ACCUM_FIRST_GUARD || sel == SEL_ACCUM_SECOND_GUARD) begin
         operand = {{32{s.acc[sel[0]][39]}}, s.acc[sel[0]][39:32]};
      end else if (isData(sel)) begin
         w = s.dat[dataIdx(sel)];
         operand = {{GUARD_W{w[31]}}, w};
      end
   endfunction

   // Only the registers the core may reach as system registers answer.
   function automatic logic coreOk(input logic [3:0] sel);
      coreOk = (sel == SEL_ACCUM_FIRST) || (sel == SEL_COND_STATUS)
         || ((sel >= SEL_XBUS_REG_FIRST) && (sel <= SEL_YBUS_REG_SECOND));
   endfunction

   // ----------------------------------------------------------------
   // Result flags from the 40-bit result
   // ----------------------------------------------------------------
   logic resNeg;
   logic resZero;
   logic resWrap;
   logic resGt;
   logic condHit;
   logic doWrite;
   logic updFlags;
   logic [2:0] curCs;
   logic [STAT_W-1:0] newStat;

   always_comb begin
      resNeg = dspWrData[ACC_W-1];
      resZero = (dspWrData == '0);
      resWrap = (dspWrData[39:32] != {GUARD_W{dspWrData[31]}});
      resGt = !resNeg && !resZero;
      curCs = s_r.stat[CS_HI:CS_LO];
      case (curCs)
         CS_CARRY: condHit = dspCarry;
         CS_NEGATIVE: condHit = resNeg;
         CS_ZERO: condHit = resZero;
         CS_OVERFLOW: condHit = resWrap;
         CS_SIGNED_GREATER: condHit = resGt;
         CS_SIGNED_ABOVE: condHit = !resNeg;
         default: condHit = 1'b0;
      endcase
      newStat = s_r.stat;
      newStat[GT_BIT] = resGt;
      newStat[EQ_BIT] = resZero;
      newStat[LT_BIT] = resNeg;
      newStat[WRAP_BIT] = resWrap;
      newStat[DC_BIT] = condHit;
      // A conditional operation waits on the flag from earlier work.
      doWrite = dspWrEn && (!dspCondOp || s_r.stat[DC_BIT]);
      updFlags = dspWrEn && !dspCondOp && (dspKind == OP_ARITH);
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = doWrite;
      if (updFlags) begin
         s_nxt.stat = newStat;
      end
      if (doWrite) begin
         if (dspWrSel == SEL_ACCUM_FIRST || dspWrSel == SEL_ACCUM_SECOND) begin
            s_nxt.acc[dspWrSel[0]] = dspWrData;
         end else if (dspWrSel == SEL_ACCUM_FIRST_GUARD
            || dspWrSel == SEL_ACCUM_SECOND_GUARD) begin
            s_nxt.acc[dspWrSel[0]][39:32] = dspWrData[7:0];
         end else if (isData(dspWrSel)) begin
            // Guard bits of the result are dropped for 32-bit targets.
            s_nxt.dat[dataIdx(dspWrSel)] = dspWrData[31:0];
         end
      end
      // Core accesses are gated only by coreOk, never by the condition flag; they win a same-cycle clash.
      if (sysWrEn && coreOk(sysWrSel)) begin
         if (sysWrSel == SEL_ACCUM_FIRST) begin
            s_nxt.acc[0] = {{GUARD_W{sysWrData[31]}}, sysWrData};
         end else if (sysWrSel == SEL_COND_STATUS) begin
            s_nxt.stat = sysWrData[STAT_W-1:0];
         end else begin
            s_nxt.dat[dataIdx(sysWrSel)] = sysWrData;
         end
      end
      s_nxt.rd = '0;
      if (coreOk(sysRdSel)) begin
         if (sysRdSel == SEL_ACCUM_FIRST) begin
            s_nxt.rd = s_r.acc[0][31:0];
         end else if (sysRdSel == SEL_COND_STATUS) begin
            s_nxt.rd = {24'h00_0000, s_r.stat};
         end else begin
            s_nxt.rd = s_r.dat[dataIdx(sysRdSel)];
         end
      end
      s_nxt.opA = operand(s_r, srcASel);
      s_nxt.opB = operand(s_r, srcBSel);
   end

   // Zero stands in for the undefined data values; only status is defined.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s_r.acc <= '0;
         s_r.dat <= '0;
         s_r.stat <= STAT_RESET[STAT_W-1:0];
         s_r.rd <= DATA_RESET;
         s_r.opA <= '0;
         s_r.opB <= '0;
         s_r.done <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sysRdData = s_r.rd;
   assign srcAData = s_r.opA;
   assign srcBData = s_r.opB;
   assign statusFlags = s_r.stat;
   assign dspCondFlag = s_r.stat[DC_BIT];
   assign dspWrDone = s_r.done;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   logic coreStatWr;
   assign coreStatWr = sysWrEn && (sysWrSel == SEL_COND_STATUS);

   AST_RESV_ZERO: assert property (
      sysRdSel == SEL_COND_STATUS |=> sysRdData == {24'h00_0000, $past(statusFlags)})
      else $error("Reserved status bits read nonzero.");
   AST_GT_FLAG: assert property (
      updFlags && !coreStatWr |=> statusFlags[GT_BIT] ==
      ($past(!dspWrData[39]) && $past(dspWrData) != 40'h00_0000_0000))
      else $error("Greater flag wrong.");
   AST_EQ_FLAG: assert property (
      updFlags && !coreStatWr && dspWrData == '0 |=> statusFlags[EQ_BIT]
      && !statusFlags[GT_BIT] && !statusFlags[LT_BIT])
      else $error("Equal flag wrong.");
   AST_LT_FLAG: assert property (
      updFlags && !coreStatWr |=> statusFlags[LT_BIT] == $past(dspWrData[39]))
      else $error("Less flag does not follow the 40-bit sign.");
   AST_WRAP_FLAG: assert property (
      updFlags && !coreStatWr && dspWrData[39:32] != {8{dspWrData[31]}}
      |=> statusFlags[WRAP_BIT])
      else $error("Wrap flag missed an overflow.");
   AST_DC_ZERO: assert property (
      updFlags && !coreStatWr && statusFlags[CS_HI:CS_LO] == CS_ZERO
      |=> dspCondFlag == statusFlags[EQ_BIT])
      else $error("Condition flag does not track zero mode.");
   AST_COND_HOLD: assert property (
      dspWrEn && dspCondOp && !coreStatWr |=> $stable(statusFlags))
      else $error("Conditional operation changed status.");
   AST_KIND_HOLD: assert property (
      dspWrEn && dspKind != OP_ARITH && !coreStatWr |=> $stable(statusFlags))
      else $error("Non-arithmetic operation changed status.");
   AST_COND_GATE: assert property (
      dspWrEn && dspCondOp && !dspCondFlag |=> !dspWrDone)
      else $error("Conditional write ran with flag clear.");
   AST_A0_GUARD: assert property (
      sysWrEn && sysWrSel == SEL_ACCUM_FIRST ##1 srcASel == SEL_ACCUM_FIRST
      |=> srcAData[39:32] == {8{srcAData[31]}} && srcAData[31:0] == $past(sysWrData, 2))
      else $error("Core write to accumulator 0 not sign-copied into guard.");
   AST_SEXT: assert property (
      isData(srcBSel) |=> srcBData[39:32] == {8{srcBData[31]}})
      else $error("Data register operand not sign-extended.");
   // Each condition mode must carry the matching flag of the same update into bit 0.
   AST_DC_CARRY: assert property (
      updFlags && !coreStatWr && statusFlags[CS_HI:CS_LO] == CS_CARRY
      |=> dspCondFlag == $past(dspCarry))
      else $error("Condition flag does not track carry mode.");
   AST_DC_NEG: assert property (
      updFlags && !coreStatWr && statusFlags[CS_HI:CS_LO] == CS_NEGATIVE
      |=> dspCondFlag == statusFlags[LT_BIT])
      else $error("Condition flag does not track negative mode.");
   AST_DC_WRAP: assert property (
      updFlags && !coreStatWr && statusFlags[CS_HI:CS_LO] == CS_OVERFLOW
      |=> dspCondFlag == statusFlags[WRAP_BIT])
      else $error("Condition flag does not track overflow mode.");
   AST_DC_GT: assert property (
      updFlags && !coreStatWr && statusFlags[CS_HI:CS_LO] == CS_SIGNED_GREATER
      |=> dspCondFlag == statusFlags[GT_BIT])
      else $error("Condition flag does not track greater mode.");
   AST_DC_ABOVE: assert property (
      updFlags && !coreStatWr && statusFlags[CS_HI:CS_LO] == CS_SIGNED_ABOVE
      |=> dspCondFlag == !statusFlags[LT_BIT])
      else $error("Condition flag does not track above mode.");
   AST_CS_HOLD: assert property (
      updFlags && !coreStatWr |=> statusFlags[CS_HI:CS_LO] == $past(statusFlags[CS_HI:CS_LO]))
      else $error("Flag update disturbed the condition select field.");
   AST_STAT_CORE: assert property (
      coreStatWr |=> statusFlags == $past(sysWrData[STAT_W-1:0]))
      else $error("Core status write not stored.");
   AST_A0_READ: assert property (
      sysRdSel == SEL_ACCUM_FIRST && srcASel == SEL_ACCUM_FIRST
      |=> sysRdData == srcAData[31:0])
      else $error("Core read of accumulator 0 does not return its body.");
   AST_REFUSED_RD: assert property (
      sysRdSel >= SEL_ACCUM_SECOND && sysRdSel <= SEL_MULT_REG_SECOND
      |=> sysRdData == 32'h0000_0000)
      else $error("Core read of a register it may not reach returned data.");
   AST_DONE_SET: assert property (
      dspWrEn && !dspCondOp |=> dspWrDone)
      else $error("Unconditional write-back not performed.");
   AST_DONE_IDLE: assert property (
      !dspWrEn |=> !dspWrDone)
      else $error("Write-back reported with no strobe.");
   AST_GUARD_WR: assert property (
      dspWrEn && !dspCondOp && dspWrSel == SEL_ACCUM_FIRST_GUARD
      && !(sysWrEn && sysWrSel == SEL_ACCUM_FIRST) ##1 srcASel == SEL_ACCUM_FIRST
      |=> srcAData[39:32] == $past(dspWrData[7:0], 2))
      else $error("Guard write did not land in accumulator 0.");

   COV_COND_SKIP: cover property (dspWrEn && dspCondOp && !dspCondFlag);
   COV_OVERFLOW: cover property (updFlags ##1 statusFlags[WRAP_BIT]);
   COV_CORE_A0: cover property (sysWrEn && sysWrSel == SEL_ACCUM_FIRST);
   COV_CORE_STAT: cover property (coreStatWr ##1 sysRdSel == SEL_COND_STATUS);
   COV_GUARD_WR: cover property (dspWrEn && dspWrSel == SEL_ACCUM_FIRST_GUARD);
endmodule
`default_nettype wire

// [tb/dsp_pipe_model.sv]
// Behavioural DSP datapath that issues write-backs into the register file.
`timescale 1ns/1ps
`default_nettype none
module dsp_pipe_model
   import dsp_regfile_pkg::*;
(
   // Clock
   input wire logic clock,
   // Write-back side
   output logic dspWrEn,
   output logic [3:0] dspWrSel,
   output logic [39:0] dspWrData,
   output logic [1:0] dspKind,
   output logic dspCondOp,
   output logic dspCarry
);
   initial begin
      dspWrEn = 1'h0;
      dspWrSel = 4'h0;
      dspWrData = 40'h00_0000_0000;
      dspKind = 2'h0;
      dspCondOp = 1'h0;
      dspCarry = 1'h0;
   end
   // Entered just after a rising edge; the data lines are scrambled once the
   // strobe drops so that a stale value can never look like a fresh one.
   task automatic issue(input logic [3:0] sel, input logic [39:0] data,
         input logic [1:0] kind, input logic cond, input logic carry);
      // An idle edge first, so back-to-back calls never drive the strobe twice in one step.
      @(posedge clock);
      #1;
      dspWrSel = sel;
      dspWrData = data;
      dspKind = kind;
      dspCondOp = cond;
      dspCarry = carry;
      dspWrEn = 1'h1;
      @(posedge clock);
      #1;
      dspWrEn = 1'h0;
      dspWrData = ~data;
   endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the DSP register file.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import dsp_regfile_pkg::*;
;
   logic clock, reset, sysWrEn, dspWrEn, dspCondOp, dspCarry, dspCondFlag, dspWrDone;
   logic [3:0] sysWrSel, sysRdSel, srcASel, srcBSel, dspWrSel;
   logic [31:0] sysWrData, sysRdData;
   logic [39:0] dspWrData, srcAData, srcBData;
   logic [1:0] dspKind;
   logic [7:0] statusFlags;
   int nErrors = 0;
   int checksDone = 0;
   int cyc = 0;
   localparam logic [39:0] RES [5] = '{40'h00_0000_0001, 40'h00_0000_0000,
      40'hFF_FFFF_FFFF, 40'h01_0000_0000, 40'h80_0000_0000};
   dsp_regfile dut(.clock(clock), .reset(reset), .sysWrEn(sysWrEn), .sysWrSel(sysWrSel),
      .sysWrData(sysWrData), .sysRdSel(sysRdSel), .sysRdData(sysRdData),
      .dspWrEn(dspWrEn), .dspWrSel(dspWrSel), .dspWrData(dspWrData), .dspKind(dspKind),
      .dspCondOp(dspCondOp), .dspCarry(dspCarry), .srcASel(srcASel), .srcBSel(srcBSel),
      .srcAData(srcAData), .srcBData(srcBData), .statusFlags(statusFlags),
      .dspCondFlag(dspCondFlag), .dspWrDone(dspWrDone));
   dsp_pipe_model pm(.clock(clock), .dspWrEn(dspWrEn), .dspWrSel(dspWrSel),
      .dspWrData(dspWrData), .dspKind(dspKind), .dspCondOp(dspCondOp), .dspCarry(dspCarry));
   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
      checksDone++;
      if (got !== exp) begin
         nErrors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] sel, input logic [31:0] data);
      sysWrSel = sel;
      sysWrData = data;
      sysWrEn = 1'h1;
      @(posedge clock);
      #1;
      sysWrEn = 1'h0;
   endtask
   task automatic rdchk(input string what, input logic [3:0] sel, input logic [31:0] exp);
      sysRdSel = sel;
      @(posedge clock);
      #1;
      chk(what, {8'h00, exp}, {8'h00, sysRdData});
   endtask
   task automatic srcchk(input string what, input logic [3:0] sel, input logic [39:0] exp);
      srcASel = sel;
      srcBSel = sel;
      @(posedge clock);
      #1;
      chk(what, exp, srcAData);
      chk(what, exp, srcBData);
   endtask
   function automatic logic [7:0] flags(input logic [39:0] r, input logic [2:0] cs,
         input logic c);
      logic gt, eq, lt, wv, dc;
      eq = (r == 40'h00_0000_0000);
      lt = r[39];
      gt = !lt && !eq;
      wv = (r[39:32] != {8{r[31]}});
      dc = cs == 3'h0 ? c : cs == 3'h1 ? lt : cs == 3'h2 ? eq : cs == 3'h3 ? wv :
         cs == 3'h4 ? gt : !lt;
      return {gt, eq, lt, wv, cs, dc};
   endfunction
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic test_core_port();
      chk("flags", 40'h0, {32'h0000_0000, statusFlags});
      rdchk("status", SEL_COND_STATUS, 32'h0000_0000);
      wr(SEL_COND_STATUS, 32'hFFFF_FF0A);
      rdchk("status", SEL_COND_STATUS, 32'h0000_000A);
      wr(SEL_ACCUM_FIRST, 32'h8000_0001);
      rdchk("acc0", SEL_ACCUM_FIRST, 32'h8000_0001);
      srcchk("acc0src", SEL_ACCUM_FIRST, 40'hFF_8000_0001);
      wr(SEL_ACCUM_SECOND, 32'h1234_5678);
      rdchk("acc1", SEL_ACCUM_SECOND, 32'h0000_0000);
      $display("test core_port done");
   endtask
   task automatic test_flags();
      logic [2:0] cs;
      logic [7:0] ef;
      for (int m = 0; m < 6; m++) begin
         for (int i = 0; i < 5; i++) begin
            // Codes 110 and 111 are never programmed.
            cs = 3'(m);
            wr(SEL_COND_STATUS, {28'h000_0000, cs, 1'h0});
            pm.issue(SEL_ACCUM_SECOND, RES[i], OP_ARITH, 1'h0, i[0]);
            ef = flags(RES[i], cs, i[0]);
            chk("flags", {32'h0, ef}, {32'h0, statusFlags});
            chk("dcflag", {39'h0, ef[0]}, {39'h0, dspCondFlag});
            chk("done", 40'h1, {39'h0, dspWrDone});
            srcchk("acc1", SEL_ACCUM_SECOND, RES[i]);
         end
      end
      $display("test flags done");
   endtask
   task automatic test_no_flag_ops();
      wr(SEL_COND_STATUS, 32'h0000_0004);
      pm.issue(SEL_MULT_REG_FIRST, 40'hAB_8000_0000, OP_PACKED_MUL, 1'h0, 1'h1);
      chk("flags", 40'h04, {32'h0, statusFlags});
      pm.issue(SEL_ACCUM_FIRST_GUARD, 40'h00_0000_0012, OP_TRANSFER, 1'h0, 1'h1);
      chk("flags", 40'h04, {32'h0, statusFlags});
      srcchk("acc0", SEL_ACCUM_FIRST, 40'h12_8000_0001);
      srcchk("m0", SEL_MULT_REG_FIRST, 40'hFF_8000_0000);
      $display("test no_flag_ops done");
   endtask
   task automatic test_cond();
      pm.issue(SEL_ACCUM_SECOND, 40'h00_0000_0000, OP_ARITH, 1'h0, 1'h0);
      pm.issue(SEL_XBUS_REG_SECOND, 40'h00_0000_0055, OP_ARITH, 1'h1, 1'h0);
      chk("done", 40'h1, {39'h0, dspWrDone});
      chk("flags", 40'h45, {32'h0, statusFlags});
      rdchk("x1", SEL_XBUS_REG_SECOND, 32'h0000_0055);
      pm.issue(SEL_ACCUM_SECOND, 40'h00_0000_0001, OP_ARITH, 1'h0, 1'h0);
      pm.issue(SEL_XBUS_REG_SECOND, 40'h00_0000_0066, OP_ARITH, 1'h1, 1'h0);
      chk("done", 40'h0, {39'h0, dspWrDone});
      chk("flags", 40'h84, {32'h0, statusFlags});
      rdchk("x1", SEL_XBUS_REG_SECOND, 32'h0000_0055);
      wr(SEL_XBUS_REG_SECOND, 32'h0000_0077);
      rdchk("x1", SEL_XBUS_REG_SECOND, 32'h0000_0077);
      $display("test cond done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checksDone, nErrors);
      if (nErrors == 0 && checksDone > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // -----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // -----------------------------------------------------------------
   initial begin
      clock = 1'h0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 2000) begin
         nErrors++;
         tally_and_finish();
      end
   end
   initial begin
      reset = 1'h1;
      sysWrEn = 1'h0;
      sysWrSel = 4'h0;
      sysWrData = 32'h0000_0000;
      sysRdSel = 4'h0;
      srcASel = 4'h0;
      srcBSel = 4'h0;
      repeat (3) @(posedge clock);
      #1;
      reset = 1'h0;
      test_core_port();
      test_flags();
      test_no_flag_ops();
      test_cond();
      tally_and_finish();
   end
endmodule
`default_nettype wire
